// File: missing_host_watchdog.sv
/*
 * missing-host watchdog with apb registers, spi frame checker and pin 0 driver.
 * assumes spi pins and pin 0 input are asynchronous to pclk; mode 0 spi, msb first.
 */
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
module missing_host_watchdog #(
  parameter int unsigned WIN1_CYCLES = watchdog_pkg::WINDOW1_CYCLES,
  parameter int unsigned WIN2_CYCLES = watchdog_pkg::WINDOW2_CYCLES,
  parameter int unsigned WIN3_CYCLES = watchdog_pkg::WINDOW3_CYCLES,
  parameter int unsigned HB_HALF_CYCLES = watchdog_pkg::HEARTBEAT_HALF_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [watchdog_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic pin0_in,
  output logic pin0_out,
  output logic pin0_oe,
  output logic irq
);
  import watchdog_pkg::*;

  // ****************************************
  // registers and apb decode
  // ****************************************
  logic [CTRL_W-1:0] ctrl;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [CNT_W-1:0] count;
  logic alarm;
  logic pin0_sync1, pin0_sync2;

  wire logic setup = psel & ~penable;
  wire logic access = psel & penable;
  wire logic hit_ctrl = (paddr == ADDR_CTRL);
  wire logic hit_count = (paddr == ADDR_COUNT);
  wire logic hit_status = (paddr == ADDR_IRQ_STATUS);
  wire logic hit_mask = (paddr == ADDR_IRQ_MASK);
  wire logic hit_pin = (paddr == ADDR_PIN);
  wire logic addr_ok = hit_ctrl | hit_count | hit_status | hit_mask | hit_pin;
  wire logic wr = access & pwrite & addr_ok;
  wire logic wr_ctrl = wr & hit_ctrl;
  wire logic wr_status = wr & hit_status;
  wire logic wr_mask = wr & hit_mask;
  wire logic [31:0] rd_mux =
    hit_ctrl ? {{(32-CTRL_W){1'b0}}, ctrl} :
    hit_count ? {{(32-CNT_W){1'b0}}, count} :
    hit_status ? {{(32-IRQ_W){1'b0}}, irq_status} :
    hit_mask ? {{(32-IRQ_W){1'b0}}, irq_mask} :
    hit_pin ? {31'h00000000, pin0_sync2} : 32'h00000000;

  assign pready = 1'b1;
  assign pslverr = access & ~addr_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
      irq_mask <= IRQ_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl <= pwdata[CTRL_W-1:0];
      end
      if (wr_mask) begin
        irq_mask <= pwdata[IRQ_W-1:0];
      end
    end
  end

  wire logic [1:0] sel = ctrl[CTRL_SEL_MSB:CTRL_SEL_LSB];

  // ****************************************
  // input synchronisers
  // ****************************************
  logic sclk_s1, sclk_s2, sclk_s3;
  logic cs_s1, cs_s2, cs_s3;
  logic mosi_s1, mosi_s2;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
      pin0_sync1 <= 1'b0;
      pin0_sync2 <= 1'b0;
    end else begin
      sclk_s1 <= spi_sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      cs_s1 <= spi_cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      mosi_s1 <= spi_mosi;
      mosi_s2 <= mosi_s1;
      pin0_sync1 <= pin0_in;
      pin0_sync2 <= pin0_sync1;
    end
  end

  wire logic sclk_rise = sclk_s2 & ~sclk_s3;
  wire logic cs_fall = ~cs_s2 & cs_s3;
  wire logic cs_rise = cs_s2 & ~cs_s3;

  // ****************************************
  // spi frame checker
  // ****************************************
  frame_state_e fstate, next_fstate;
  logic [FRAME_BITS-1:0] shift;
  logic [BITCNT_W-1:0] bitcnt;
  logic [CRC_W-1:0] crc;

  always_comb begin
    next_fstate = fstate;
    unique case (fstate)
      FR_IDLE: begin
        if (cs_fall) begin
          next_fstate = FR_SHIFT;
        end
      end
      FR_SHIFT: begin
        if (cs_rise) begin
          next_fstate = FR_EVAL;
        end
      end
      FR_EVAL: begin
        next_fstate = FR_IDLE;
      end
      default: begin
        next_fstate = FR_IDLE;
      end
    endcase
  end

  wire logic take_bit = (fstate == FR_SHIFT) & sclk_rise & ~cs_s2;
  wire logic [BITCNT_W-1:0] next_bitcnt = (bitcnt == BITCNT_MAX) ? bitcnt : bitcnt + BITCNT_W'(1);
  wire logic frame_end = (fstate == FR_EVAL);
  wire logic frame_ok = (bitcnt == BITCNT_FRAME) && cmd_valid(shift[FRAME_BITS-1:CRC_W])
                        && (crc == shift[CRC_W-1:0]);
  wire logic frame_good = frame_end & frame_ok;
  wire logic frame_bad = frame_end & ~frame_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fstate <= FR_IDLE;
      shift <= '0;
      bitcnt <= '0;
      crc <= CRC_INIT;
    end else begin
      fstate <= next_fstate;
      if (cs_fall) begin
        bitcnt <= '0;
        crc <= CRC_INIT;
      end else if (take_bit) begin
        shift <= {shift[FRAME_BITS-2:0], mosi_s2};
        bitcnt <= next_bitcnt;
        if (bitcnt < BITCNT_CMD) begin
          crc <= crc8_step(crc, mosi_s2);
        end
      end
    end
  end

  // ****************************************
  // watchdog counter and alarm
  // ****************************************
  function automatic logic [CNT_W-1:0] window_last(input logic [1:0] code);
    unique case (code)
      SEL_WIN1: window_last = CNT_W'(WIN1_CYCLES - 1);
      SEL_WIN2: window_last = CNT_W'(WIN2_CYCLES - 1);
      SEL_WIN3: window_last = CNT_W'(WIN3_CYCLES - 1);
      SEL_OFF: window_last = '0;
    endcase
  endfunction : window_last

  logic enabled_d;
  wire logic enabled = (sel != SEL_OFF);
  wire logic enable_edge = enabled & ~enabled_d;
  wire logic timeout_hit = enabled & ~alarm & ~frame_good & ~enable_edge & (count == window_last(sel));
  wire logic restart = ~enabled | enable_edge | frame_good;
  wire logic [CNT_W-1:0] next_count = restart ? '0 : (alarm ? count : count + CNT_W'(1));
  wire logic next_alarm = enabled & (alarm | timeout_hit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enabled_d <= 1'b0;
      count <= '0;
      alarm <= 1'b0;
    end else begin
      enabled_d <= enabled;
      count <= next_count;
      alarm <= next_alarm;
    end
  end

  // ****************************************
  // interrupts from frame events only
  // ****************************************
  wire logic [IRQ_W-1:0] irq_events = {frame_bad, frame_good};
  wire logic [IRQ_W-1:0] irq_clear = wr_status ? pwdata[IRQ_W-1:0] : '0;
  wire logic [IRQ_W-1:0] next_irq_status = (irq_status & ~irq_clear) | irq_events;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= IRQ_RESET;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ****************************************
  // heartbeat and pin 0
  // ****************************************
  logic heartbeat;
  logic [CNT_W-1:0] hb_cnt;
  wire logic hb_wrap = (hb_cnt == CNT_W'(HB_HALF_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hb_cnt <= '0;
      heartbeat <= 1'b0;
    end else begin
      hb_cnt <= hb_wrap ? '0 : hb_cnt + CNT_W'(1);
      if (hb_wrap) begin
        heartbeat <= ~heartbeat;
      end
    end
  end

  pin0_shaper u_pin0 (
    .pclk(pclk),
    .presetn(presetn),
    .alarm(alarm),
    .heartbeat(heartbeat),
    .direction(ctrl[CTRL_DIR]),
    .source_select(ctrl[CTRL_SRC]),
    .output_format(ctrl[CTRL_FMT]),
    .polarity(ctrl[CTRL_POL]),
    .manual_value(ctrl[CTRL_MANUAL]),
    .pin_out(pin0_out),
    .pin_oe(pin0_oe)
  );

  // ****************************************
  // assertions
  // ****************************************
  wire logic shows_alarm = ctrl[CTRL_DIR] & ~ctrl[CTRL_SRC];

  sequence s_enable;
    (sel == SEL_OFF) ##1 (sel != SEL_OFF);
  endsequence

  sequence s_expire;
    enabled && !alarm && !frame_good && !enable_edge && (count == window_last(sel));
  endsequence

  property p_good_frame_restarts;
    @(posedge pclk) disable iff (!presetn) frame_good |=> (count == '0);
  endproperty
  a_good_frame_restarts: assert property (p_good_frame_restarts) else $error("good frame did not restart count");

  property p_expire_alarms;
    @(posedge pclk) disable iff (!presetn) s_expire |=> alarm ##1 (alarm || sel == SEL_OFF);
  endproperty
  a_expire_alarms: assert property (p_expire_alarms) else $error("window expiry did not raise alarm");

  property p_alarm_no_status;
    @(posedge pclk) disable iff (!presetn)
      (!alarm && !frame_end && !wr_status) ##1 alarm |-> (irq_status == $past(irq_status));
  endproperty
  a_alarm_no_status: assert property (p_alarm_no_status) else $error("alarm touched status bits");

  property p_off_holds_clear;
    @(posedge pclk) disable iff (!presetn) (sel == SEL_OFF) |=> (count == '0) && !alarm;
  endproperty
  a_off_holds_clear: assert property (p_off_holds_clear) else $error("disabled watchdog not clear");

  property p_alarm_sticky;
    @(posedge pclk) disable iff (!presetn) alarm && (sel != SEL_OFF) |=> alarm;
  endproperty
  a_alarm_sticky: assert property (p_alarm_sticky) else $error("alarm dropped while enabled");

  property p_pin_input_mode;
    @(posedge pclk) disable iff (!presetn) !ctrl[CTRL_DIR] |=> !pin0_oe && !pin0_out;
  endproperty
  a_pin_input_mode: assert property (p_pin_input_mode) else $error("pin driven while input");

  property p_static_active_high;
    @(posedge pclk) disable iff (!presetn)
      shows_alarm && !ctrl[CTRL_FMT] && ctrl[CTRL_POL] |=> (pin0_out == $past(alarm));
  endproperty
  a_static_active_high: assert property (p_static_active_high) else $error("active high level wrong");

  property p_active_low;
    @(posedge pclk) disable iff (!presetn)
      shows_alarm && !ctrl[CTRL_FMT] && !ctrl[CTRL_POL] |=> (pin0_out == !$past(alarm));
  endproperty
  a_active_low: assert property (p_active_low) else $error("active low level wrong");

  property p_heartbeat;
    @(posedge pclk) disable iff (!presetn)
      shows_alarm && ctrl[CTRL_FMT] |=> (pin0_out == ($past(alarm) ? $past(ctrl[CTRL_POL]) : $past(heartbeat)));
  endproperty
  a_heartbeat: assert property (p_heartbeat) else $error("heartbeat format wrong");

  property p_enable_restarts;
    @(posedge pclk) disable iff (!presetn) s_enable |=> (count == '0) ##1 (count <= CNT_W'(1));
  endproperty
  a_enable_restarts: assert property (p_enable_restarts) else $error("enable did not restart count");
endmodule : missing_host_watchdog

// File: pin0_shaper.sv
/*
 * output stage of the shared pin 0: source select, polarity and format.
 * assumes alarm and heartbeat come from logic on the same pclk.
 */
`timescale 1ns/1ps
module pin0_shaper (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic alarm,
  input wire logic heartbeat,
  input wire logic direction,
  input wire logic source_select,
  input wire logic output_format,
  input wire logic polarity,
  input wire logic manual_value,
  output logic pin_out,
  output logic pin_oe
);
  // ****************************************
  // level selection
  // ****************************************
  wire logic inactive_level = output_format ? heartbeat : ~polarity;
  wire logic alarm_level = alarm ? polarity : inactive_level;
  wire logic next_pin_out = direction & (source_select ? manual_value : alarm_level);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      pin_out <= next_pin_out;
      pin_oe <= direction;
    end
  end
endmodule : pin0_shaper

// File: spi_host_model.sv
/*
 * host side of the spi link: mode 0, msb first, chip select active low.
 * assumes the bench calls send from one process at a time.
 */
`timescale 1ns/1ps
module spi_host_model (
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi
);
  // ****************************************
  // idle levels
  // ****************************************
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b1;
  end

  // ****************************************
  // one frame of n bits, 800 ns sclk period
  // ****************************************
  task automatic send(input logic [23:0] f, input int n);
    #137 spi_cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      spi_mosi = f[i];
      #400 spi_sclk = 1'b1;
      #400 spi_sclk = 1'b0;
    end
    #200 spi_cs_n = 1'b1;
    // released line shows the inverse of the last bit
    spi_mosi = ~spi_mosi;
  endtask : send
endmodule : spi_host_model

// File: testbench.sv
/*
 * self-checking bench of the missing-host watchdog over apb and spi.
 * assumes zero-wait apb slave and shortened windows of 300/600/900 cycles.
 */
`timescale 1ns/1ps
module testbench;
  import watchdog_pkg::*;
  localparam int W1 = 300;
  localparam int W2 = 600;
  localparam int W3 = 900;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic spi_sclk;
  logic spi_cs_n;
  logic spi_mosi;
  logic pin0_in = 1'b0;
  logic pin0_out;
  logic pin0_oe;
  logic irq;
  int mismatches = 0;
  int checked = 0;
  int wins[3] = '{W1, W2, W3};
  int ones;

  always #50 pclk = ~pclk;

  missing_host_watchdog #(.WIN1_CYCLES(W1), .WIN2_CYCLES(W2), .WIN3_CYCLES(W3), .HB_HALF_CYCLES(4)) i_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .pin0_in(pin0_in), .pin0_out(pin0_out), .pin0_oe(pin0_oe),
    .irq(irq));

  spi_host_model i_host (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi));

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      mismatches++;
      $display("ERROR %0t apb slave never ready", $time);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] r;
    logic e;
    apb(a, 1'b0, 32'h0, r, e);
    chk(r, exp, "read data");
    chk({31'h0, e}, {31'h0, experr}, "slave error");
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  function automatic logic [31:0] ctl(input logic [1:0] s, input logic p, input logic src, input logic f,
                                      input logic m);
    ctl = {25'h0, m, f, src, 1'b1, p, s};
  endfunction : ctl

  function automatic logic [23:0] frm(input logic [15:0] c);
    logic [7:0] crc;
    crc = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ c[i]) ? 8'h07 : 8'h00);
    end
    frm = {c, crc};
  endfunction : frm

  task automatic good();
    i_host.send(frm(16'h1234), 24);
    cyc(10);
  endtask : good

  task automatic tally_and_finish();
    $display("TB: checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // ****************************************
  // watchdog
  // ****************************************
  initial begin
    #5ms;
    mismatches++;
    $display("ERROR %0t run timed out", $time);
    tally_and_finish();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    cyc(8);
    presetn <= 1'b1;
    rd(ADDR_CTRL, 32'h0, 1'b0);
    rd(ADDR_IRQ_STATUS, 32'h0, 1'b0);
    rd(ADDR_IRQ_MASK, 32'h0, 1'b0);
    rd(12'h100, 32'h0, 1'b1);
    wr(ADDR_COUNT, 32'hffff);
    rd(ADDR_COUNT, 32'h0, 1'b0);
    pin0_in <= 1'b1;
    cyc(4);
    rd(ADDR_PIN, 32'h1, 1'b0);
    wr(ADDR_CTRL, ctl(SEL_WIN1, 0, 0, 0, 0));
    cyc(3);
    chk(pin0_out, 1, "inactive level");
    chk(pin0_oe, 1, "pin drives");
    repeat (3) good();
    chk(pin0_out, 1, "host present");
    rd(ADDR_IRQ_STATUS, 32'h1, 1'b0);
    i_host.send(frm(16'h1234) ^ 24'h1, 24);
    cyc(10);
    i_host.send(frm(16'hffff), 24);
    cyc(10);
    i_host.send(frm(16'h1234) >> 1, 23);
    cyc(10);
    chk(pin0_out, 0, "alarm after bad frames");
    rd(ADDR_IRQ_STATUS, 32'h3, 1'b0);
    chk(irq, 0, "no irq while masked");
    good();
    chk(pin0_out, 0, "alarm holds");
    wr(ADDR_IRQ_MASK, 32'h1);
    cyc(1);
    chk(irq, 1, "irq raised");
    wr(ADDR_IRQ_STATUS, 32'h1);
    cyc(1);
    chk(irq, 0, "irq cleared");
    rd(ADDR_IRQ_STATUS, 32'h2, 1'b0);
    wr(ADDR_CTRL, ctl(SEL_WIN1, 0, 1, 0, 1));
    cyc(3);
    chk(pin0_out, 1, "manual one");
    wr(ADDR_CTRL, ctl(SEL_WIN1, 0, 0, 0, 1));
    cyc(3);
    chk(pin0_out, 0, "alarm source");
    wr(ADDR_CTRL, ctl(SEL_OFF, 0, 0, 0, 0));
    cyc(3);
    chk(pin0_out, 1, "released by zero");
    rd(ADDR_COUNT, 32'h0, 1'b0);
    for (int k = 1; k <= 3; k++) begin
      wr(ADDR_CTRL, ctl(k[1:0], 0, 0, 0, 0));
      cyc(wins[k-1] - 5);
      chk(pin0_out, 1, "before window");
      cyc(10);
      chk(pin0_out, 0, "after window");
      wr(ADDR_CTRL, ctl(SEL_OFF, 0, 0, 0, 0));
    end
    wr(ADDR_CTRL, ctl(SEL_OFF, 1, 0, 0, 0));
    cyc(3);
    chk(pin0_out, 0, "inverted inactive");
    wr(ADDR_CTRL, ctl(SEL_WIN1, 1, 0, 0, 0));
    cyc(W1 + 10);
    chk(pin0_out, 1, "inverted active");
    wr(ADDR_CTRL, ctl(SEL_OFF, 0, 0, 1, 0));
    cyc(3);
    ones = 0;
    repeat (80) begin
      @(posedge pclk);
      ones += int'(pin0_out === 1'b1);
    end
    chk(ones, 40, "heartbeat duty");
    wr(ADDR_CTRL, ctl(SEL_WIN1, 0, 0, 1, 0));
    cyc(W1 + 10);
    ones = 0;
    repeat (16) begin
      @(posedge pclk);
      ones += int'(pin0_out !== 1'b0);
    end
    chk(ones, 0, "static active");
    wr(ADDR_CTRL, 32'h0);
    cyc(3);
    chk(pin0_oe, 0, "pin released");
    tally_and_finish();
  end
endmodule : testbench

// File: watchdog_pkg.sv
/*
 * constants, field layout and helper functions of the missing-host watchdog.
 * assumes a 10 MHz pclk and an spi frame of one command word and one crc byte.
 */
package watchdog_pkg;
  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned WINDOW1_MS = 10;
  localparam int unsigned WINDOW2_MS = 50;
  localparam int unsigned WINDOW3_MS = 200;
  localparam int unsigned WINDOW1_CYCLES = WINDOW1_MS * (CLK_HZ / 1000);
  localparam int unsigned WINDOW2_CYCLES = WINDOW2_MS * (CLK_HZ / 1000);
  localparam int unsigned WINDOW3_CYCLES = WINDOW3_MS * (CLK_HZ / 1000);
  localparam int unsigned HEARTBEAT_US = 1000;
  localparam int unsigned HEARTBEAT_HALF_CYCLES = (HEARTBEAT_US * (CLK_HZ / 1_000_000)) / 2;
  localparam int CNT_W = 24;

  // ****************************************
  // register map
  // ****************************************
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_COUNT = 12'h004;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h008;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h00c;
  localparam logic [11:0] ADDR_PIN = 12'h010;
  localparam int CTRL_W = 7;
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_SEL_MSB = 1;
  localparam int CTRL_POL = 2;
  localparam int CTRL_DIR = 3;
  localparam int CTRL_SRC = 4;
  localparam int CTRL_FMT = 5;
  localparam int CTRL_MANUAL = 6;
  localparam logic [6:0] CTRL_RESET = 7'h00;
  localparam int IRQ_W = 2;
  localparam int IRQ_GOOD = 0;
  localparam int IRQ_BAD = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam logic [1:0] SEL_OFF = 2'h0;
  localparam logic [1:0] SEL_WIN1 = 2'h1;
  localparam logic [1:0] SEL_WIN2 = 2'h2;
  localparam logic [1:0] SEL_WIN3 = 2'h3;

  // ****************************************
  // spi frame
  // ****************************************
  localparam int FRAME_BITS = 24;
  localparam int CMD_BITS = 16;
  localparam int CRC_W = 8;
  localparam int BITCNT_W = 5;
  localparam logic [4:0] BITCNT_MAX = 5'h1f;
  localparam logic [4:0] BITCNT_FRAME = 5'h18;
  localparam logic [4:0] BITCNT_CMD = 5'h10;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [15:0] CMD_ALL_ZERO = 16'h0000;
  localparam logic [15:0] CMD_ALL_ONES = 16'hffff;

  typedef enum logic [2:0] {
    FR_IDLE = 3'b001,
    FR_SHIFT = 3'b010,
    FR_EVAL = 3'b100
  } frame_state_e;

  function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic din);
    crc8_step = {crc[6:0], 1'b0} ^ ((crc[7] ^ din) ? CRC_POLY : 8'h00);
  endfunction : crc8_step

  function automatic logic cmd_valid(input logic [15:0] cmd);
    cmd_valid = (cmd != CMD_ALL_ZERO) && (cmd != CMD_ALL_ONES);
  endfunction : cmd_valid
endpackage : watchdog_pkg
